/* rtl/slbt_regs.vh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * break-capable serial transmitter.
 * Assumes a byte address of 8 bits and 32-bit register words.
 */
`ifndef SLBT_REGS_VH
`define SLBT_REGS_VH

`define SLBT_ADDR_W         8
`define SLBT_FRAME_CTRL_ONE 8'h00
`define SLBT_FRAME_CTRL_TWO 8'h04
`define SLBT_FRAME_CTRL_THR 8'h08
`define SLBT_BAUD_DIVIDER   8'h0C
`define SLBT_TX_DATA        8'h10
`define SLBT_STATUS         8'h14

`define SLBT_WORD9_BIT      0
`define SLBT_BREAK_BIT      0
`define SLBT_TX_ON_BIT      1
`define SLBT_LIN_EN_BIT     0

`define SLBT_ST_BUSY_BIT    0
`define SLBT_ST_FULL_BIT    1
`define SLBT_ST_EMPTY_BIT   2
`define SLBT_ST_BREAK_BIT   3

`define SLBT_BAUD_RESET     8'h00
`define SLBT_OVERSAMPLE     16
`define SLBT_SUB_LAST       4'hF
`define SLBT_BRK_BITS_8     4'hA
`define SLBT_BRK_BITS_9     4'hB
`define SLBT_BRK_BITS_LIN   4'hD
`define SLBT_IDLE_BITS      4'hA
`define SLBT_FRAME_BITS_8   4'hA
`define SLBT_FRAME_BITS_9   4'hB

`define SLBT_FIFO_W         9
`define SLBT_FIFO_D         16
`define SLBT_FIFO_AW        4

`endif

/* rtl/slbt_fifo.v */
/*
 * Synchronous first-in first-out buffer built from flip-flops.
 * Assumes one clock; both sides use valid and ready handshakes.
 */
`timescale 1ns/1ns
`default_nettype none

module slbt_fifo #(
    parameter W  = 9,
    parameter D  = 16,
    parameter AW = 4
) (
    input  wire         sys_clk,
    input  wire         resetn,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0]  mem_r [0:D-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0]   count_r;
    wire         push;
    wire         pop;

    assign in_ready  = (count_r != D[AW:0]);
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign out_data  = mem_r[rd_ptr_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge sys_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule // slbt_fifo

`default_nettype wire

/* rtl/slbt_transmitter.v */
/*
 * Serial transmitter with break, idle-frame and LIN master header support.
 * Assumes a register master on sys_clk that never waits and a serial line
 * whose far end samples at the programmed baud rate.
 */
// Implementation choices: the register addresses and the address-and-strobe port.
// Overview of operation
// - Writing send-break one then zero yields exactly one break character.
// - Plain break lasts 10 bits for 8-bit words, 11 for 9-bit, never doubled.
// - While send-break stays set, breaks repeat back to back; none after clearing.
// - LIN master mode is LIN enable set with the word-size bit clear.
// - A LIN master break lasts 13 bit periods, never longer.
// - Transmitter enable off then on queues an idle frame; following break is exact.
// - The idle frame holds the line high for 10 bit periods.
// - LIN header goes out as break, then synch field, then identifier field.
// - Divider value C9 hex on an 8 MHz clock gives 19200 baud.
// - The line is sampled sixteen times per bit period.
`include "slbt_regs.vh"
`timescale 1ns/1ns
`default_nettype none

module slbt_transmitter (
    input  wire                    sys_clk,
    input  wire                    resetn,
    input  wire [`SLBT_ADDR_W-1:0] reg_addr,
    input  wire [31:0]             reg_wdata,
    input  wire                    reg_wr,
    input  wire                    reg_rd,
    output reg  [31:0]             reg_rdata_r,
    output reg                     txd_r,
    output reg                     sample_tick_r,
    output reg                     tx_buf_ready_r
);
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_IFRM = 4'b0010;
    localparam [3:0] ST_BRK  = 4'b0100;
    localparam [3:0] ST_DATA = 4'b1000;

    reg  [3:0]  state_r;
    reg  [3:0]  state_nxt;
    reg         word9_r;
    reg         send_break_request;
    reg         tx_on;
    reg         lin_en_r;
    reg  [7:0]  baud_divider;
    reg         brk_pend_r;
    reg         idle_pend_r;
    reg  [15:0] div_cnt_r;
    reg  [3:0]  sub_r;
    reg  [3:0]  bits_left_r;
    reg  [3:0]  bits_left_nxt;
    reg  [10:0] shift_r;
    reg  [10:0] shift_nxt;
    reg         txd_nxt;
    reg         start_brk;
    reg         start_idle;
    reg         pop_ready;
    wire        lin_master;
    wire        bit_end;
    wire        brk_rise;
    wire        on_rise;
    wire        wr_two;
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire [8:0]  fifo_out_data;
    wire        fifo_push;

    // Clock cycles per oversampling tick: prescaler times a power of two.
    function [15:0] tick_len;
        input [7:0] brr;
        reg   [3:0] pr;
        begin
            case (brr[7:6])
                2'b00:   pr = 4'h1;
                2'b01:   pr = 4'h3;
                2'b10:   pr = 4'h4;
                default: pr = 4'hD;
            endcase
            tick_len = {12'h000, pr} << brr[5:3];
        end
    endfunction

    // Break length in bits for the current word size and mode.
    function [3:0] break_bits;
        input lin;
        input w9;
        begin
            if (lin) begin
                break_bits = `SLBT_BRK_BITS_LIN;
            end else if (w9) begin
                break_bits = `SLBT_BRK_BITS_9;
            end else begin
                break_bits = `SLBT_BRK_BITS_8;
            end
        end
    endfunction

    assign lin_master = lin_en_r & ~word9_r;
    assign bit_end    = sample_tick_r && (sub_r == `SLBT_SUB_LAST);
    assign wr_two     = reg_wr && (reg_addr == `SLBT_FRAME_CTRL_TWO);
    assign brk_rise   = wr_two && reg_wdata[`SLBT_BREAK_BIT] && !send_break_request;
    assign on_rise    = wr_two && reg_wdata[`SLBT_TX_ON_BIT] && !tx_on;
    assign fifo_push  = reg_wr && (reg_addr == `SLBT_TX_DATA);

    slbt_fifo #(
        .W  (`SLBT_FIFO_W),
        .D  (`SLBT_FIFO_D),
        .AW (`SLBT_FIFO_AW)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .in_data   (reg_wdata[8:0]),
        .out_valid (fifo_out_valid),
        .out_ready (pop_ready),
        .out_data  (fifo_out_data)
    );

    // Register writes and the read port.
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            word9_r            <= 1'b0;
            send_break_request <= 1'b0;
            tx_on              <= 1'b0;
            lin_en_r           <= 1'b0;
            baud_divider       <= `SLBT_BAUD_RESET;
            reg_rdata_r        <= 32'h0000_0000;
            tx_buf_ready_r     <= 1'b0;
        end else begin
            tx_buf_ready_r <= fifo_in_ready;
            if (reg_wr) begin
                if (reg_addr == `SLBT_FRAME_CTRL_ONE) begin
                    word9_r <= reg_wdata[`SLBT_WORD9_BIT];
                end else if (reg_addr == `SLBT_FRAME_CTRL_TWO) begin
                    send_break_request <= reg_wdata[`SLBT_BREAK_BIT];
                    tx_on              <= reg_wdata[`SLBT_TX_ON_BIT];
                end else if (reg_addr == `SLBT_FRAME_CTRL_THR) begin
                    lin_en_r <= reg_wdata[`SLBT_LIN_EN_BIT];
                end else if (reg_addr == `SLBT_BAUD_DIVIDER) begin
                    baud_divider <= reg_wdata[7:0];
                end
            end
            reg_rdata_r <= 32'h0000_0000;
            if (reg_rd) begin
                if (reg_addr == `SLBT_FRAME_CTRL_ONE) begin
                    reg_rdata_r[`SLBT_WORD9_BIT] <= word9_r;
                end else if (reg_addr == `SLBT_FRAME_CTRL_TWO) begin
                    reg_rdata_r[`SLBT_BREAK_BIT] <= send_break_request;
                    reg_rdata_r[`SLBT_TX_ON_BIT] <= tx_on;
                end else if (reg_addr == `SLBT_FRAME_CTRL_THR) begin
                    reg_rdata_r[`SLBT_LIN_EN_BIT] <= lin_en_r;
                end else if (reg_addr == `SLBT_BAUD_DIVIDER) begin
                    reg_rdata_r[7:0] <= baud_divider;
                end else if (reg_addr == `SLBT_STATUS) begin
                    reg_rdata_r[`SLBT_ST_BUSY_BIT]  <= (state_r != ST_IDLE);
                    reg_rdata_r[`SLBT_ST_FULL_BIT]  <= !fifo_in_ready;
                    reg_rdata_r[`SLBT_ST_EMPTY_BIT] <= !fifo_out_valid;
                    reg_rdata_r[`SLBT_ST_BREAK_BIT] <= (state_r == ST_BRK);
                end
            end
        end
    end

    // The sixteen-times tick also serves a receiver sampler on the same divider.
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            div_cnt_r     <= 16'h0000;
            sample_tick_r <= 1'b0;
        end else begin
            if (div_cnt_r >= tick_len(baud_divider) - 16'h0001) begin
                div_cnt_r     <= 16'h0000;
                sample_tick_r <= 1'b1;
            end else begin
                div_cnt_r     <= div_cnt_r + 16'h0001;
                sample_tick_r <= 1'b0;
            end
        end
    end

    // The idle frame goes first, so a break always starts from a clean bit
    // boundary and cannot merge with a frame still draining.
    always @* begin
        state_nxt     = state_r;
        bits_left_nxt = bits_left_r;
        shift_nxt     = shift_r;
        txd_nxt       = txd_r;
        start_brk     = 1'b0;
        start_idle    = 1'b0;
        pop_ready     = 1'b0;
        case (state_r)
            ST_IDLE: begin
                txd_nxt = 1'b1;
                if (tx_on && idle_pend_r) begin
                    start_idle    = 1'b1;
                    state_nxt     = ST_IFRM;
                    bits_left_nxt = `SLBT_IDLE_BITS;
                end else if (tx_on && brk_pend_r) begin
                    start_brk     = 1'b1;
                    state_nxt     = ST_BRK;
                    bits_left_nxt = break_bits(lin_master, word9_r) + 4'h1;
                    txd_nxt       = 1'b0;
                end else if (tx_on) begin
                    pop_ready = 1'b1;
                    if (fifo_out_valid) begin
                        state_nxt = ST_DATA;
                        if (word9_r) begin
                            shift_nxt     = {1'b1, fifo_out_data, 1'b0};
                            bits_left_nxt = `SLBT_FRAME_BITS_9;
                        end else begin
                            shift_nxt     = {2'b11, fifo_out_data[7:0], 1'b0};
                            bits_left_nxt = `SLBT_FRAME_BITS_8;
                        end
                        txd_nxt = 1'b0;
                    end
                end
            end
            ST_IFRM: begin
                txd_nxt = 1'b1;
                if (bit_end) begin
                    bits_left_nxt = bits_left_r - 4'h1;
                    if (bits_left_r == 4'h1) begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_BRK: begin
                if (bit_end) begin
                    bits_left_nxt = bits_left_r - 4'h1;
                    txd_nxt       = (bits_left_r == 4'h2);
                    if (bits_left_r == 4'h1) begin
                        if (send_break_request && tx_on) begin
                            start_brk     = 1'b1;
                            bits_left_nxt = break_bits(lin_master, word9_r) + 4'h1;
                            txd_nxt       = 1'b0;
                        end else begin
                            state_nxt = ST_IDLE;
                            txd_nxt   = 1'b1;
                        end
                    end
                end
            end
            ST_DATA: begin
                if (bit_end) begin
                    bits_left_nxt = bits_left_r - 4'h1;
                    shift_nxt     = {1'b1, shift_r[10:1]};
                    txd_nxt       = shift_r[1];
                    if (bits_left_r == 4'h1) begin
                        state_nxt = ST_IDLE;
                        txd_nxt   = 1'b1;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                txd_nxt   = 1'b1;
            end
        endcase
    end

    // Bit counters and line state; a new request set in the cycle it is taken
    // survives because the set term wins over the clear term.
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_r     <= ST_IDLE;
            bits_left_r <= 4'h0;
            shift_r     <= 11'h7FF;
            txd_r       <= 1'b1;
            sub_r       <= 4'h0;
            brk_pend_r  <= 1'b0;
            idle_pend_r <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            bits_left_r <= bits_left_nxt;
            shift_r     <= shift_nxt;
            txd_r       <= txd_nxt;
            brk_pend_r  <= brk_rise | (brk_pend_r & ~start_brk);
            idle_pend_r <= on_rise | (idle_pend_r & ~start_idle);
            if (state_r == ST_IDLE) begin
                sub_r <= 4'h0;
            end else if (sample_tick_r) begin
                sub_r <= sub_r + 4'h1;
            end
        end
    end
endmodule // slbt_transmitter

`default_nettype wire

/* verification/slbt_chk_assertions.sv */
/* Checker for the break-capable serial transmitter.
   Assumes it is bound to the transmitter top and sees only its ports. */
`include "slbt_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module slbt_chk (
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata_r,
    input wire logic        txd_r,
    input wire logic        sample_tick_r,
    input wire logic        tx_buf_ready_r
);
    logic [15:0] lo_r, hi_r, gap_r;
    logic [7:0]  brr_r;
    logic        w9_r, lin_r, sbk_r, brk_r, ok_r;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Control bits are shadowed from the write strobes, as the checker sees no registers.
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            {lo_r, hi_r, gap_r, brr_r, w9_r, lin_r, sbk_r, brk_r, ok_r} <= '0;
        end else begin
            lo_r  <= txd_r ? 16'h0000 : lo_r + 16'(sample_tick_r);
            hi_r  <= txd_r ? hi_r + 16'(sample_tick_r) : 16'h0000;
            gap_r <= sample_tick_r ? 16'h0000 : gap_r + 16'h0001;
            brk_r <= txd_r & sbk_r & (brk_r | (lo_r > 16'h0098));
            ok_r  <= (brr_r == 8'hC9) & (ok_r | sample_tick_r);
            w9_r  <= (reg_wr && reg_addr == `SLBT_FRAME_CTRL_ONE) ? reg_wdata[0] : w9_r;
            sbk_r <= (reg_wr && reg_addr == `SLBT_FRAME_CTRL_TWO) ? reg_wdata[0] : sbk_r;
            lin_r <= (reg_wr && reg_addr == `SLBT_FRAME_CTRL_THR) ? reg_wdata[0] : lin_r;
            brr_r <= (reg_wr && reg_addr == `SLBT_BAUD_DIVIDER) ? reg_wdata[7:0] : brr_r;
        end
    end
    sequence s_low_end;
        $rose(txd_r);
    endsequence
    sequence s_brk_gap;
        brk_r && sbk_r && txd_r;
    endsequence
    AST_BRK_PLAIN8: assert property (s_low_end ##0 (!w9_r && !lin_r) |-> lo_r <= 16'h00A1)
        else $error("plain break longer than ten bits");
    AST_BRK_WORD9: assert property (s_low_end ##0 w9_r |-> lo_r <= 16'h00B1)
        else $error("nine-bit break longer than eleven bits");
    AST_BRK_LIN: assert property (s_low_end ##0 (lin_r && !w9_r) |->
        (lo_r <= 16'h0091 || (lo_r >= 16'h00CF && lo_r <= 16'h00D1)))
        else $error("master break not thirteen bits");
    AST_BRK_REPEAT: assert property (s_brk_gap |-> hi_r <= 16'h0011)
        else $error("held break did not repeat after one stop bit");
    AST_TICK_C9: assert property (sample_tick_r && ok_r |-> gap_r == 16'h0019)
        else $error("tick spacing wrong for divider C9");
    AST_TICK_PULSE: assert property (sample_tick_r && brr_r[7:3] != 5'h00
        |=> !sample_tick_r)
        else $error("sample tick wider than one cycle");
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata_r == 32'h0000_0000)
        else $error("read data not zero outside read answer");
    AST_BAUD_RB: assert property (reg_rd && reg_addr == `SLBT_BAUD_DIVIDER |=>
        reg_rdata_r == {24'h00_0000, brr_r})
        else $error("divider readback wrong");
endmodule // slbt_chk
bind slbt_transmitter slbt_chk chk_u (.sys_clk(sys_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r), .txd_r(txd_r), .sample_tick_r(sample_tick_r),
    .tx_buf_ready_r(tx_buf_ready_r));
`default_nettype wire

/* verification/slbt_lin_node.sv */
/* Remote serial node: measures low runs and receives 8-bit frames.
   Assumes the transmitter's sixteen-per-bit tick as its own sampling clock. */
`timescale 1ns/1ns
`default_nettype none
module slbt_lin_node (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        txd,
    input  wire logic        tick,
    output var  logic [15:0] lo_ticks,
    output var  logic [15:0] lo_cyc,
    output var  logic [7:0]  brk_cnt,
    output var  logic [7:0]  rx_cnt,
    output var  logic [15:0] rx_hist
);
    logic [15:0] run_t, run_c;
    logic [7:0]  t_r;
    logic [9:0]  sh_r;
    logic        prev_r, busy_r;
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            {lo_ticks, lo_cyc, brk_cnt, rx_cnt, rx_hist, run_t, run_c, t_r, sh_r, busy_r} <= '0;
            prev_r <= 1'b1;
        end else begin
            prev_r <= txd;
            if (!txd) begin
                run_t <= run_t + 16'(tick);
                run_c <= run_c + 16'h0001;
            end else if (!prev_r) begin // A low run over nine and a half bits is a break.
                lo_ticks <= run_t;
                lo_cyc   <= run_c;
                run_t    <= 16'h0000;
                run_c    <= 16'h0000;
                brk_cnt  <= brk_cnt + 8'(run_t > 16'h0098);
            end
            if (!busy_r && prev_r && !txd) begin
                busy_r <= 1'b1;
                t_r    <= 8'h00;
            end else if (busy_r && tick && t_r[3:0] != 4'h7) begin
                t_r <= t_r + 8'h01;
            end else if (busy_r && tick) begin // Mid-bit sample; low stop drops it.
                t_r     <= t_r + 8'h01;
                sh_r    <= {txd, sh_r[9:1]};
                busy_r  <= t_r[7:4] != 4'h9;
                rx_cnt  <= rx_cnt + 8'(txd && t_r[7:4] == 4'h9);
                rx_hist <= (txd && t_r[7:4] == 4'h9) ? {rx_hist[7:0], sh_r[9:2]} : rx_hist;
            end
        end
    end
endmodule // slbt_lin_node
`default_nettype wire

/* verification/tb_top.sv */
/* Self-checking bench for the break-capable serial transmitter.
   Assumes the remote node model and the bound checker are compiled alongside. */
`include "slbt_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic        sys_clk, resetn, reg_wr, reg_rd, meas, meas_go;
    logic [7:0]  reg_addr, b0, r0;
    logic [31:0] reg_wdata, d;
    logic [15:0] idle_t;
    wire  [31:0] reg_rdata_r;
    wire         txd_r, sample_tick_r, tx_buf_ready_r;
    wire  [15:0] lo_ticks, lo_cyc, rx_hist;
    wire  [7:0]  brk_cnt, rx_cnt;
    int          bad_count, compares, i, k;
    logic [15:0] mode_t [4] = '{16'h00A0, 16'h00B0, 16'h00B0, 16'h00D0};
    localparam logic [7:0] c1 = `SLBT_FRAME_CTRL_ONE;
    localparam logic [7:0] c2 = `SLBT_FRAME_CTRL_TWO;
    localparam logic [7:0] c3 = `SLBT_FRAME_CTRL_THR;
    localparam logic [7:0] dr = `SLBT_TX_DATA;
    localparam logic [7:0] bd = `SLBT_BAUD_DIVIDER;
    slbt_transmitter dut_u (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
        .txd_r(txd_r), .sample_tick_r(sample_tick_r), .tx_buf_ready_r(tx_buf_ready_r));
    slbt_lin_node node_u (.sys_clk(sys_clk), .resetn(resetn), .txd(txd_r),
        .tick(sample_tick_r), .lo_ticks(lo_ticks), .lo_cyc(lo_cyc), .brk_cnt(brk_cnt),
        .rx_cnt(rx_cnt), .rx_hist(rx_hist));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // The measurement is restarted from here only, so the task never races this process.
    always @(posedge sys_clk) begin
        idle_t <= meas_go ? 16'h0000 : idle_t + 16'(meas && txd_r && sample_tick_r);
        meas   <= meas_go || (meas && txd_r);
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata_r;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_run(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] tol);
        compares++;
        if ((got + tol >= exp && got <= exp + tol) !== 1'b1) begin
            bad_count++;
            $display("mismatch at %0t: run %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_cnt(input logic [7:0] n, input logic rx);
        k = 0;
        while ((rx ? rx_cnt : brk_cnt) !== n && k < 20000) begin
            @(posedge sys_clk);
            k++;
        end
    endtask
    // Enable toggle first, so the break follows an idle frame with nothing in between.
    task automatic send_break();
        wr(c2, 32'h0000_0000);
        wr(c2, 32'h0000_0002);
        meas_go <= 1'b1;
        wr(c2, 32'h0000_0003);
        meas_go <= 1'b0;
        wr(c2, 32'h0000_0002);
    endtask
    task automatic final_report();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, meas_go} = '0;
        bad_count = 0;
        compares = 0;
        resetn = 1'b0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(bd, d);
        chk(d, 32'h0000_0000);
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, d);
        chk(d, 32'h0000_0000);
        for (i = 0; i < 4; i++) begin
            wr(c1, 32'(i[0] ^ i[1]));
            wr(c3, 32'(i[1]));
            b0 = brk_cnt;
            send_break();
            wait_cnt(b0 + 8'h01, 1'b0);
            repeat (400) @(posedge sys_clk);
            chk(32'(brk_cnt), 32'(b0 + 8'h01));
            chk_run(lo_ticks, mode_t[i], 16'h0001);
            chk_run(idle_t, 16'h00A0, 16'h0002);
        end
        wr(c1, 32'h0000_0000);
        wr(c3, 32'h0000_0000);
        b0 = brk_cnt;
        wr(c2, 32'h0000_0003);
        wait_cnt(b0 + 8'h01, 1'b0);
        @(negedge txd_r);
        rd(`SLBT_STATUS, d);
        chk(32'(d[3:0]), 32'h0000_000D);
        wr(c2, 32'h0000_0002);
        repeat (600) @(posedge sys_clk);
        chk(32'(brk_cnt), 32'(b0 + 8'h02));
        wr(c3, 32'h0000_0001);
        b0 = brk_cnt;
        r0 = rx_cnt;
        send_break();
        wr(dr, 32'h0000_0055);
        wr(dr, 32'h0000_003C);
        wait_cnt(b0 + 8'h01, 1'b0);
        chk(32'(rx_cnt), 32'(r0));
        wait_cnt(r0 + 8'h02, 1'b1);
        chk(32'(rx_hist), 32'h0000_553C);
        wr(c3, 32'h0000_0000);
        wr(c2, 32'h0000_0000);
        for (i = 0; i < 17; i++) begin
            wr(dr, 32'(i));
        end
        @(negedge sys_clk);
        chk(32'(tx_buf_ready_r), 32'h0000_0000);
        rd(`SLBT_STATUS, d);
        chk(32'(d[1]), 32'h0000_0001);
        r0 = rx_cnt;
        wr(c2, 32'h0000_0002);
        wait_cnt(r0 + 8'h10, 1'b1);
        repeat (400) @(posedge sys_clk);
        chk(32'(rx_cnt), 32'(r0 + 8'h10));
        chk(32'(rx_hist), 32'h0000_0E0F);
        rd(`SLBT_STATUS, d);
        chk(32'(d[2]), 32'h0000_0001);
        wr(bd, 32'h0000_00C9);
        rd(bd, d);
        chk(d, 32'h0000_00C9);
        b0 = brk_cnt;
        send_break();
        wait_cnt(b0 + 8'h01, 1'b0);
        chk_run(lo_cyc, 16'h1040, 16'h001A);
        chk_run(lo_ticks, 16'h00A0, 16'h0001);
        final_report();
    end
    initial begin
        repeat (60000) @(posedge sys_clk);
        bad_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        final_report();
    end
endmodule // tb_top
`default_nettype wire
